// file: cir_pkg.sv
// constants for the command and interrupt control register page
// assumes an 8-bit register port with 6-bit register addresses on the core clock
package cir_pkg;

  localparam logic [5:0] ADDR_RSVD = 6'h00;
  localparam logic [5:0] ADDR_CMD = 6'h01;
  localparam logic [5:0] ADDR_MAIN_EN = 6'h02;
  localparam logic [5:0] ADDR_AUX_EN = 6'h03;
  localparam logic [5:0] ADDR_MAIN_FLAGS = 6'h04;
  localparam logic [5:0] ADDR_AUX_FLAGS = 6'h05;

  localparam logic [7:0] RST_CMD = 8'h20;
  localparam logic [7:0] RST_MAIN_EN = 8'h80;
  localparam logic [7:0] RST_AUX_EN = 8'h00;
  localparam logic [7:0] RST_MAIN_FLAGS = 8'h14;
  localparam logic [7:0] RST_AUX_FLAGS = 8'h00;

  // command register fields
  localparam int CMD_RCV_OFF_BIT = 5;
  localparam int CMD_SLEEP_BIT = 4;
  // enable and flag registers
  localparam int POLARITY_FLIP_BIT = 7;
  localparam int DRIVE_STYLE_BIT = 7;
  localparam int SET_CLEAR_BIT = 7;
  localparam int CMD_END_FLAG_BIT = 4;
  localparam int AUX_EDGE_BIT = 4;
  localparam int CHECKSUM_BIT = 2;
  localparam logic [7:0] AUX_USED_MASK = 8'h14;
  localparam logic [6:0] MAIN_USED_MASK = 7'h7f;

  // command codes, plain defaults; the set of known codes is a bit mask
  localparam logic [3:0] CMD_IDLE = 4'h0;
  localparam logic [3:0] CMD_SELF_RESTART = 4'hf;
  localparam logic [15:0] CMD_KNOWN_MASK = 16'hffff;

  typedef enum logic [1:0] {CIR_AWAKE, CIR_ASLEEP, CIR_WAKING} cir_sleep_t;

endpackage

// file: cir_sync.sv
// two-flop synchroniser, one per bit
// assumes the inputs are asynchronous to i_core_clk
`timescale 1ns/100ps
module cir_sync #(
  parameter int W = 2
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge i_core_clk or negedge i_nrst)
      begin
        if (!i_nrst)
        begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end
        else
        begin
          meta_reg <= i_async[g];
          sync_reg <= meta_reg;
        end
      end
      assign o_sync[g] = sync_reg;
    end
  endgenerate

endmodule

// file: cir_ctrl.sv
// command register, interrupt enables and request flags, irq pin driver
// assumes host port logic on i_core_clk presents one-cycle read/write strobes
//
// Behaviour
// - offset zero is reserved, reads zero, has no function.
// - command register resets to 0x20; bit 5 switches receiver analog part off.
// - writing 1 to sleep bit 4 enters soft power-down.
// - clearing sleep bit starts wake-up; bit reads 1 until ready, then 0.
// - setting sleep bit is ignored while self-restart command is active.
// - host writes command code in bits 3:0; reads return executing code.
// - polarity flip bit 7 inverts the summary request on the irq pin.
// - main enable resets to 0x80, leaving open-drain irq pin released.
// - main enable bits 6:0 gate tx, rx, cmd end, high, low, fault, timer.
// - aux enable bit 7 selects push-pull irq pin, else open-drain.
// - aux enable resets zero; bit 4 gates input edge, bit 2 checksum.
// - main flags at offset four reset 0x14; bit 7 write-only; hardware sets rest.
// - flag write: marked flags set if bit 7 is 1, cleared if 0.
// - unknown command code reverts to idle and sets the command end flag.
// - host writing the idle command does not set the command end flag.
`timescale 1ns/100ps
module cir_ctrl (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [5:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic [6:0] i_main_events,
  input wire logic i_checksum_done,
  input wire logic i_cmd_done,
  input wire logic i_aux_card_input,
  input wire logic i_osc_ready,
  output logic [3:0] o_cmd_code,
  output logic o_cmd_start,
  output logic o_receiver_analog_off,
  output logic o_soft_sleep,
  output logic o_irq_out,
  output logic o_irq_oe
);

  logic [1:0] sync_out;
  logic aux_in_s;
  logic osc_ready_s;

  cir_sync #(.W(2)) u_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async({i_osc_ready, i_aux_card_input}),
    .o_sync(sync_out)
  );
  assign aux_in_s = sync_out[0];
  assign osc_ready_s = sync_out[1];

  logic [3:0] cmd_reg, cmd_next;
  logic rcv_off_reg, rcv_off_next;
  logic start_reg, start_next;
  cir_pkg::cir_sleep_t sleep_reg, sleep_next;
  logic sleep_out_reg, sleep_out_next;
  logic [7:0] main_en_reg, main_en_next;
  logic [7:0] aux_en_reg, aux_en_next;
  logic [6:0] main_flags_reg, main_flags_next;
  logic [7:0] aux_flags_reg, aux_flags_next;
  logic aux_prev_reg, aux_prev_next;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_out_reg, irq_out_next;
  logic irq_oe_reg, irq_oe_next;

  logic wr_cmd, wr_main_en, wr_aux_en, wr_main_flags, wr_aux_flags;
  logic cmd_end_set;
  logic aux_edge;
  logic summary;
  logic irq_level;

  assign wr_cmd = i_reg_wr && (i_reg_addr == cir_pkg::ADDR_CMD);
  assign wr_main_en = i_reg_wr && (i_reg_addr == cir_pkg::ADDR_MAIN_EN);
  assign wr_aux_en = i_reg_wr && (i_reg_addr == cir_pkg::ADDR_AUX_EN);
  assign wr_main_flags = i_reg_wr && (i_reg_addr == cir_pkg::ADDR_MAIN_FLAGS);
  assign wr_aux_flags = i_reg_wr && (i_reg_addr == cir_pkg::ADDR_AUX_FLAGS);
  assign aux_edge = aux_in_s ^ aux_prev_reg;

  // command field and command start
  always_comb
  begin
    cmd_next = cmd_reg;
    rcv_off_next = rcv_off_reg;
    start_next = 1'b0;
    cmd_end_set = 1'b0;
    if (i_cmd_done && (cmd_reg != cir_pkg::CMD_IDLE))
    begin
      // a finished command returns to idle and reports its end
      cmd_next = cir_pkg::CMD_IDLE;
      cmd_end_set = 1'b1;
    end
    if (wr_cmd)
    begin
      rcv_off_next = i_reg_wdata[cir_pkg::CMD_RCV_OFF_BIT];
      if (i_reg_wdata[3:0] == cir_pkg::CMD_IDLE)
      begin
        cmd_next = cir_pkg::CMD_IDLE;
      end
      else if (!cir_pkg::CMD_KNOWN_MASK[i_reg_wdata[3:0]])
      begin
        cmd_next = cir_pkg::CMD_IDLE;
        cmd_end_set = 1'b1;
      end
      else
      begin
        cmd_next = i_reg_wdata[3:0];
        start_next = 1'b1;
      end
    end
  end

  // soft power-down sequencing
  always_comb
  begin
    sleep_next = sleep_reg;
    case (sleep_reg)
      cir_pkg::CIR_AWAKE:
      begin
        if (wr_cmd && i_reg_wdata[cir_pkg::CMD_SLEEP_BIT] && (cmd_reg != cir_pkg::CMD_SELF_RESTART))
        begin
          sleep_next = cir_pkg::CIR_ASLEEP;
        end
      end
      cir_pkg::CIR_ASLEEP:
      begin
        if (wr_cmd && !i_reg_wdata[cir_pkg::CMD_SLEEP_BIT])
        begin
          sleep_next = cir_pkg::CIR_WAKING;
        end
      end
      cir_pkg::CIR_WAKING:
      begin
        // oscillator ready ends the wake-up; bit keeps reading 1 until then
        if (osc_ready_s)
        begin
          sleep_next = cir_pkg::CIR_AWAKE;
        end
      end
      default:
      begin
        sleep_next = cir_pkg::CIR_AWAKE;
      end
    endcase
    sleep_out_next = (sleep_next == cir_pkg::CIR_ASLEEP);
  end

  // enables and sticky flags; hardware set always wins over a host clear
  always_comb
  begin
    main_en_next = main_en_reg;
    aux_en_next = aux_en_reg;
    main_flags_next = main_flags_reg;
    aux_flags_next = aux_flags_reg;
    aux_prev_next = aux_in_s;
    if (wr_main_en)
    begin
      main_en_next = i_reg_wdata;
    end
    if (wr_aux_en)
    begin
      aux_en_next = i_reg_wdata & (cir_pkg::AUX_USED_MASK | (8'h01 << cir_pkg::DRIVE_STYLE_BIT));
    end
    if (wr_main_flags)
    begin
      if (i_reg_wdata[cir_pkg::SET_CLEAR_BIT])
      begin
        main_flags_next = main_flags_reg | i_reg_wdata[6:0];
      end
      else
      begin
        main_flags_next = main_flags_reg & ~i_reg_wdata[6:0];
      end
    end
    if (wr_aux_flags)
    begin
      if (i_reg_wdata[cir_pkg::SET_CLEAR_BIT])
      begin
        aux_flags_next = aux_flags_reg | (i_reg_wdata & cir_pkg::AUX_USED_MASK);
      end
      else
      begin
        aux_flags_next = aux_flags_reg & ~(i_reg_wdata & cir_pkg::AUX_USED_MASK);
      end
    end
    main_flags_next = main_flags_next | (i_main_events & cir_pkg::MAIN_USED_MASK);
    main_flags_next[cir_pkg::CMD_END_FLAG_BIT] = main_flags_next[cir_pkg::CMD_END_FLAG_BIT] | cmd_end_set;
    aux_flags_next[cir_pkg::AUX_EDGE_BIT] = aux_flags_next[cir_pkg::AUX_EDGE_BIT] | aux_edge;
    aux_flags_next[cir_pkg::CHECKSUM_BIT] = aux_flags_next[cir_pkg::CHECKSUM_BIT] | i_checksum_done;
  end

  // irq pin, one cycle behind the flags
  always_comb
  begin
    summary = |(main_flags_reg & main_en_reg[6:0]) |
              (|(aux_flags_reg & aux_en_reg & cir_pkg::AUX_USED_MASK));
    irq_level = summary ^ main_en_reg[cir_pkg::POLARITY_FLIP_BIT];
    if (aux_en_reg[cir_pkg::DRIVE_STYLE_BIT])
    begin
      irq_out_next = irq_level;
      irq_oe_next = 1'b1;
    end
    else
    begin
      // open-drain: pull low only, release for high
      irq_out_next = 1'b0;
      irq_oe_next = !irq_level;
    end
  end

  // read data, registered one cycle after the read strobe
  always_comb
  begin
    rdata_next = rdata_reg;
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        cir_pkg::ADDR_RSVD: rdata_next = 8'h00;
        cir_pkg::ADDR_CMD: rdata_next = {2'b00, rcv_off_reg, (sleep_reg != cir_pkg::CIR_AWAKE), cmd_reg};
        cir_pkg::ADDR_MAIN_EN: rdata_next = main_en_reg;
        cir_pkg::ADDR_AUX_EN: rdata_next = aux_en_reg;
        cir_pkg::ADDR_MAIN_FLAGS: rdata_next = {1'b0, main_flags_reg};
        cir_pkg::ADDR_AUX_FLAGS: rdata_next = aux_flags_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cmd_reg <= cir_pkg::RST_CMD[3:0];
      rcv_off_reg <= cir_pkg::RST_CMD[cir_pkg::CMD_RCV_OFF_BIT];
      start_reg <= 1'b0;
      sleep_reg <= cir_pkg::CIR_AWAKE;
      sleep_out_reg <= 1'b0;
      main_en_reg <= cir_pkg::RST_MAIN_EN;
      aux_en_reg <= cir_pkg::RST_AUX_EN;
      main_flags_reg <= cir_pkg::RST_MAIN_FLAGS[6:0];
      aux_flags_reg <= cir_pkg::RST_AUX_FLAGS;
      aux_prev_reg <= 1'b0;
      rdata_reg <= 8'h00;
      irq_out_reg <= 1'b0;
      irq_oe_reg <= 1'b0;
    end
    else
    begin
      cmd_reg <= cmd_next;
      rcv_off_reg <= rcv_off_next;
      start_reg <= start_next;
      sleep_reg <= sleep_next;
      sleep_out_reg <= sleep_out_next;
      main_en_reg <= main_en_next;
      aux_en_reg <= aux_en_next;
      main_flags_reg <= main_flags_next;
      aux_flags_reg <= aux_flags_next;
      aux_prev_reg <= aux_prev_next;
      rdata_reg <= rdata_next;
      irq_out_reg <= irq_out_next;
      irq_oe_reg <= irq_oe_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_cmd_code = cmd_reg;
  assign o_cmd_start = start_reg;
  assign o_receiver_analog_off = rcv_off_reg;
  assign o_soft_sleep = sleep_out_reg;
  assign o_irq_out = irq_out_reg;
  assign o_irq_oe = irq_oe_reg;

endmodule

// file: cir_host.sv
// host model: single-byte register writes and reads on the strobe port
// assumes a strobe is taken at the next rising clock edge
`timescale 1ns/100ps
module cir_host (
  input wire logic i_core_clk,
  input wire logic [7:0] i_rdata,
  output logic [5:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  int gap = 0;
  initial {o_addr, o_wr, o_rd, o_wdata} = '0;
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    repeat (gap + 1) @(posedge i_core_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    // stale data inverted so it cannot pass for a fresh byte
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    repeat (gap + 1) @(posedge i_core_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_core_clk);
    o_rd <= 1'b0;
    #1 d = i_rdata;
  endtask
endmodule

// file: cir_ctrl_chk.sv
// assertions on the cir_ctrl ports
// assumes one clock and an async low reset
`timescale 1ns/100ps
module cir_ctrl_chk (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [5:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [3:0] o_cmd_code,
  input wire logic o_cmd_start,
  input wire logic o_receiver_analog_off,
  input wire logic o_soft_sleep,
  input wire logic o_irq_out,
  input wire logic o_irq_oe
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);
  sequence s_cmd_wr;
    i_reg_wr && i_reg_addr == cir_pkg::ADDR_CMD;
  endsequence
  a_code_from_wr: assert property (s_cmd_wr |=> o_cmd_code == $past(i_reg_wdata[3:0]))
    else $error("code");
  a_rcv_off_bit: assert property (s_cmd_wr |=>
    o_receiver_analog_off == $past(i_reg_wdata[cir_pkg::CMD_RCV_OFF_BIT])) else $error("rcv off");
  a_start_cause: assert property (o_cmd_start |-> $past(i_reg_wr && i_reg_addr == cir_pkg::ADDR_CMD))
    else $error("start");
  a_start_single: assert property (o_cmd_start |=> !o_cmd_start)
    else $error("start len");
  a_idle_no_start: assert property (s_cmd_wr ##0 (i_reg_wdata[3:0] == cir_pkg::CMD_IDLE) |=> !o_cmd_start)
    else $error("idle start");
  a_sleep_locked: assert property (s_cmd_wr ##0 (o_cmd_code == cir_pkg::CMD_SELF_RESTART && !o_soft_sleep)
    |=> !o_soft_sleep) else $error("sleep");
  a_wake_clears: assert property (s_cmd_wr ##0 !i_reg_wdata[cir_pkg::CMD_SLEEP_BIT] |=> !o_soft_sleep)
    else $error("wake");
  a_od_release: assert property (!o_irq_oe |-> !o_irq_out)
    else $error("drain");
endmodule
bind cir_ctrl cir_ctrl_chk u_chk (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_cmd_code(o_cmd_code), .o_cmd_start(o_cmd_start),
  .o_receiver_analog_off(o_receiver_analog_off), .o_soft_sleep(o_soft_sleep), .o_irq_out(o_irq_out),
  .o_irq_oe(o_irq_oe));

// file: command_and_irq_control_regs_bench.sv
// bench for cir_ctrl with a host model and a flag and pin model
// assumes design, host model and bound checker compiled first
`timescale 1ns/100ps
module command_and_irq_control_regs_bench;
  logic clk = 1'b0;
  logic nrst, wr, rd, cks, done, card, osc, aoff, slp, out, oe;
  logic [5:0] addr;
  logic [7:0] wd, rdat, rv;
  logic [6:0] ev;
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 32'h9e8f_8a9a;
  int mf = 0, af = 0, men, aen;
  int rstv[7] = '{0, 8'h20, 8'h80, 0, 8'h14, 0, 0};
  initial forever #25 clk = ~clk;
  cir_ctrl u_dut (.i_core_clk(clk), .i_nrst(nrst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wd), .o_reg_rdata(rdat), .i_main_events(ev), .i_checksum_done(cks), .i_cmd_done(done),
    .i_aux_card_input(card), .i_osc_ready(osc), .o_cmd_code(), .o_cmd_start(),
    .o_receiver_analog_off(aoff), .o_soft_sleep(slp), .o_irq_out(out), .o_irq_oe(oe));
  cir_host u_host (.i_core_clk(clk), .i_rdata(rdat), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wd));
  task chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    n_errors += int'(g !== e);
    if (g !== e) $display("unexpected at %0t: %h not %h", $time, g, e);
  endtask
  task rdc(input int a, input int e);
    u_host.rd(6'(a), rv);
    chk(rv, 8'(e));
  endtask
  task pulse(input int m);
    @(posedge clk) ev <= 7'(m);
    @(posedge clk) ev <= 7'h00;
    mf |= m;
  endtask
  // open drain only pulls low, so a high level shows as released
  task pin_chk;
    int s;
    repeat (2) @(posedge clk);
    s = int'(|(mf & men & 8'h7f | af & aen & 8'h14)) ^ men[7];
    #1 chk({6'h00, oe, out}, 8'(aen[7] ? 2 + s : 2 - 2 * s));
  endtask
  task test_done;
    $display("%0d checks, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    {nrst, ev, cks, done, card, osc} = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    #1 chk({6'h00, oe, out}, 8'h00);
    for (int a = 0; a < 7; a++) rdc(a, rstv[a]);
    u_host.wr(6'h00, 8'hff);
    rdc(0, 0);
    u_host.wr(6'h04, 8'h7f);
    u_host.wr(6'h01, 8'hcc);
    rdc(1, 8'h0c);
    chk({7'h00, aoff}, 8'h00);
    @(posedge clk) done <= 1'b1;
    @(posedge clk) done <= 1'b0;
    rdc(1, 0);
    rdc(4, 8'h10);
    u_host.wr(6'h04, 8'h10);
    u_host.wr(6'h01, 8'h20);
    #1 chk({7'h00, aoff}, 8'h01);
    rdc(1, 8'h20);
    rdc(4, 0);
    $display("command test ended");
    for (int i = 0; i < 7; i++)
    begin
      u_host.gap = $random(seed) & 3;
      men = 1 << i | $random(seed) & 8'h80;
      aen = $random(seed) & 8'h80;
      u_host.wr(6'h04, 8'h7f);
      u_host.wr(6'h02, 8'(men));
      u_host.wr(6'h03, 8'(aen));
      mf = 0;
      pulse(8'h7f & ~(1 << i));
      pin_chk;
      u_host.wr(6'h04, 8'(8'h80 | 1 << i));
      mf = 8'h7f;
      pin_chk;
    end
    rdc(4, 8'h7f);
    // clear of all flags lands on the same edge as a tx event: the event must survive
    u_host.gap = 0;
    fork
      u_host.wr(6'h04, 8'h7f);
      begin
        @(posedge clk) ev <= 7'h40;
        @(posedge clk) ev <= 7'h00;
      end
    join
    rdc(4, 8'h40);
    u_host.wr(6'h04, 8'h7f);
    mf = 0;
    u_host.wr(6'h03, 8'hff);
    rdc(3, 8'h94);
    u_host.wr(6'h03, 8'h84);
    aen = 8'h84;
    @(posedge clk) cks <= 1'b1;
    @(posedge clk) cks <= 1'b0;
    af = 4;
    pin_chk;
    @(posedge clk) card <= 1'b1;
    repeat (6) @(posedge clk);
    rdc(5, 8'h14);
    $display("irq test ended");
    u_host.wr(6'h01, 8'h10);
    #1 chk({7'h00, slp}, 8'h01);
    u_host.wr(6'h01, 8'h00);
    rdc(1, 8'h10);
    @(posedge clk) osc <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(1, 0);
    u_host.wr(6'h01, 8'h0f);
    u_host.wr(6'h01, 8'h1f);
    rdc(1, 8'h0f);
    $display("sleep test ended");
    test_done;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    n_errors++;
    test_done;
  end
endmodule
